// ===== mdc_config_regs.sv
`timescale 1ns/10ps
// Functional notes
// - monitor-enable bit 27 of setup one turns the analog monitor output on.
// - bits 4:3 pick serial pin drive: 4.8, 3.9, 1.86, 30.8 mA.
// - bit 2 switches pull-ups on fault indicator and speed feedback pins.
// - bits 1:0 pick supply range 15, 30, 60 V; code 3 unused.
// - setup one sits at A6h and resets to all zeros.
// - setup two sits at A8h, resets to zero: internal clock, no watchdog.
// - sleep after speed input stays low 50us, 200us, 20ms or 200ms.
// - frequency mode duty is input frequency over full-scale bits 30:16.
// - refresh within 100ms/1s, 200ms/2s, 500ms/3s, 1000ms/10s by pin/serial.
// - on expiry report only if bit 0 low, else latch and float bridges.
module mdc_config_regs
  import mdc_pkg::*;
#(
  parameter int SLEEP_CYC_0 = SLEEP_CYC0,
  parameter int SLEEP_CYC_1 = SLEEP_CYC1,
  parameter int SLEEP_CYC_2 = SLEEP_CYC2,
  parameter int SLEEP_CYC_3 = SLEEP_CYC3,
  parameter int MS_CYCLES   = MS_CYC,
  parameter int GATE_CYCLES = FREQ_GATE_CYC
) (
  input  wire logic        clk_in,                      // core clock
  input  wire logic        rst_in,                      // async reset, high
  input  wire logic [7:0]  reg_addr_in,                 // register offset
  input  wire logic [31:0] reg_wdata_in,                // write data
  input  wire logic        reg_wr_in,                   // write strobe
  input  wire logic        reg_rd_in,                   // read strobe
  output logic [31:0]      reg_rdata_out,               // read data, next cycle
  input  wire logic        speed_pin_in,                // speed command pin
  input  wire logic        speed_freq_mode_in,          // speed input in freq mode
  input  wire logic        refresh_pin_in,              // watchdog refresh pin
  input  wire logic        serial_refresh_in,           // serial refresh pulse
  output logic             analog_monitor_pin_en_out,   // monitor output on
  output logic [6:0]       target_addr_out,             // serial bus address
  output logic [1:0]       serial_drive_sel_out,        // serial pin drive code
  output logic             fault_indicator_pin_pu_out,  // pull-up on
  output logic             speed_feedback_pin_pu_out,   // pull-up on
  output logic [1:0]       max_supply_range_out,        // supply range code
  output logic             sleep_out,                   // sleep entered
  output logic             standby_out,                 // standby entered
  output logic             csa_gain_auto_out,           // current gain adapt
  output logic             volt_gain_auto_out,          // voltage gain adapt
  output logic [1:0]       clk_sel_out,                 // clock source
  output logic             ext_clk_en_out,              // external clock mode
  output logic [2:0]       ext_clk_cfg_out,             // external clock rate
  output logic [DUTY_W-1:0] freq_duty_out,              // duty from frequency
  output logic             freq_duty_valid_out,         // pulse, new duty
  output logic             wdt_fault_out,               // watchdog fault seen
  output logic             bridge_hiz_out               // output FETs floated
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mdc_setup_one_s one;
    mdc_setup_two_s two;
    logic [31:0]    rdata;
    logic           spd_meta;
    logic           spd_sync;
    logic           spd_prev;
    logic           ref_meta;
    logic           ref_sync;
    logic           ref_prev;
    logic [31:0]    ms_cnt;
    logic [13:0]    wdt_ms;
    logic           report;
    logic           latched;
  } mdc_regs_st_s;

  mdc_regs_st_s   st_q, st_d;
  mdc_bus_req_s   req;
  mdc_setup_one_s one_wr;
  mdc_setup_two_s two_wr;
  logic           asleep;
  logic           spd_edge;
  logic           refresh;
  logic           ms_tick;
  logic           expire;
  logic [13:0]    limit;
  logic [31:0]    status;

  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in,
                 wr: reg_wr_in, rd: reg_rd_in};

  function automatic logic [13:0] wdt_limit(input logic       pin_src,
                                            input logic [1:0] sel);
    logic [13:0] ms;
    ms = '0;
    case ({pin_src, sel})
      3'h4:    ms = 14'(WDT_PIN_MS0);
      3'h5:    ms = 14'(WDT_PIN_MS1);
      3'h6:    ms = 14'(WDT_PIN_MS2);
      3'h7:    ms = 14'(WDT_PIN_MS3);
      3'h0:    ms = 14'(WDT_SER_MS0);
      3'h1:    ms = 14'(WDT_SER_MS1);
      3'h2:    ms = 14'(WDT_SER_MS2);
      default: ms = 14'(WDT_SER_MS3);
    endcase
    return ms;
  endfunction : wdt_limit

  // ----------------------------------------------------------------
  // derived strobes
  // ----------------------------------------------------------------
  assign spd_edge = st_q.spd_sync & ~st_q.spd_prev;
  // only the selected refresh source counts; the other is ignored
  assign refresh  = st_q.two.wdt_pin_src ? (st_q.ref_sync & ~st_q.ref_prev)
                                         : serial_refresh_in;
  assign ms_tick  = st_q.two.wdt_en && (st_q.ms_cnt == 32'(MS_CYCLES - 1));
  assign limit    = wdt_limit(st_q.two.wdt_pin_src,
                              st_q.two.refresh_interval_select);
  assign expire   = ms_tick && !refresh && (st_q.wdt_ms + 14'h1 >= limit);

  always_comb begin
    status                  = '0;
    status[STAT_REPORT_BIT] = st_q.report;
    status[STAT_LATCH_BIT]  = st_q.latched;
    status[STAT_SLEEP_BIT]  = asleep;
  end

  always_comb begin
    one_wr = mdc_setup_one_s'(req.wdata & SETUP_ONE_WMSK);
    if (one_wr.max_supply_range == RANGE_RESERVED) begin
      // the reserved range would leave the supply monitor undefined
      one_wr.max_supply_range = st_q.one.max_supply_range;
    end
    two_wr = mdc_setup_two_s'(req.wdata & SETUP_TWO_WMSK);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d          = st_q;
    st_d.spd_meta = speed_pin_in;
    st_d.spd_sync = st_q.spd_meta;
    st_d.spd_prev = st_q.spd_sync;
    st_d.ref_meta = refresh_pin_in;
    st_d.ref_sync = st_q.ref_meta;
    st_d.ref_prev = st_q.ref_sync;

    st_d.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        SETUP_ONE_OFS: st_d.rdata = st_q.one;
        SETUP_TWO_OFS: st_d.rdata = st_q.two;
        STATUS_OFS:    st_d.rdata = status;
        default:       st_d.rdata = '0;
      endcase
    end

    if (req.wr) begin
      case (req.addr)
        SETUP_ONE_OFS: st_d.one = one_wr;
        SETUP_TWO_OFS: st_d.two = two_wr;
        STATUS_OFS: begin
          if (req.wdata[STAT_REPORT_BIT]) begin
            st_d.report = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // watchdog: a refresh restarts the interval, disabling parks it
    if (!st_q.two.wdt_en) begin
      st_d.ms_cnt = '0;
      st_d.wdt_ms = '0;
    end else begin
      st_d.ms_cnt = ms_tick ? '0 : st_q.ms_cnt + 32'h1;
      if (refresh) begin
        st_d.wdt_ms = '0;
      end else if (expire) begin
        st_d.wdt_ms = '0;
      end else if (ms_tick) begin
        st_d.wdt_ms = st_q.wdt_ms + 14'h1;
      end
    end

    // set wins over a software clear in the same cycle
    if (expire) begin
      st_d.report = 1'b1;
      if (st_q.two.watchdog_expiry_action) begin
        st_d.latched = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q     <= '0;
      st_q.one <= mdc_setup_one_s'(SETUP_ONE_RST);
      st_q.two <= mdc_setup_two_s'(SETUP_TWO_RST);
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  mdc_sleep_timer #(
    .CYC0 (SLEEP_CYC_0),
    .CYC1 (SLEEP_CYC_1),
    .CYC2 (SLEEP_CYC_2),
    .CYC3 (SLEEP_CYC_3)
  ) u_sleep (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .low_in     (~st_q.spd_sync),
    .sel_in     (st_q.two.sleep_sel),
    .asleep_out (asleep)
  );

  mdc_freq_duty #(
    .GATE_CYC (GATE_CYCLES)
  ) u_freq (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .en_in     (speed_freq_mode_in),
    .edge_in   (spd_edge),
    .fmax_in   (st_q.two.fmax),
    .duty_out  (freq_duty_out),
    .valid_out (freq_duty_valid_out)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out              = st_q.rdata;
  assign analog_monitor_pin_en_out  = st_q.one.mon_en;
  assign target_addr_out            = st_q.one.target_addr;
  assign serial_drive_sel_out       = st_q.one.drive_sel;
  assign fault_indicator_pin_pu_out = st_q.one.pullup_en;
  assign speed_feedback_pin_pu_out  = st_q.one.pullup_en;
  assign max_supply_range_out       = st_q.one.max_supply_range;
  // the low-power state reached is the one picked by the mode bit
  assign sleep_out                  = asleep & st_q.two.sleep_mode;
  assign standby_out                = asleep & ~st_q.two.sleep_mode;
  assign csa_gain_auto_out          = st_q.two.csa_auto;
  assign volt_gain_auto_out         = st_q.two.volt_auto;
  assign clk_sel_out                = st_q.two.clk_sel;
  assign ext_clk_en_out             = st_q.two.ext_clk_en;
  assign ext_clk_cfg_out            = st_q.two.ext_clk_cfg;
  assign wdt_fault_out              = st_q.report | st_q.latched;
  assign bridge_hiz_out             = st_q.latched;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_wr_one;
    req.wr && req.addr == SETUP_ONE_OFS;
  endsequence

  sequence s_latch_expiry;
    expire && st_q.two.watchdog_expiry_action;
  endsequence

  property p_mon_follow;
    @(posedge clk_in) disable iff (rst_in)
    s_wr_one |=> analog_monitor_pin_en_out == $past(reg_wdata_in[27]);
  endproperty
  a_mon_follow: assert property (p_mon_follow) else $error("monitor bit lost");

  property p_drive_follow;
    @(posedge clk_in) disable iff (rst_in)
    s_wr_one |=> serial_drive_sel_out == $past(reg_wdata_in[4:3]);
  endproperty
  a_drive_follow: assert property (p_drive_follow) else $error("drive code lost");

  property p_pullup_pair;
    @(posedge clk_in) disable iff (rst_in)
    s_wr_one |=> fault_indicator_pin_pu_out == $past(reg_wdata_in[2])
                 && speed_feedback_pin_pu_out == fault_indicator_pin_pu_out;
  endproperty
  a_pullup_pair: assert property (p_pullup_pair) else $error("pull-up wrong");

  property p_range_legal;
    @(posedge clk_in) disable iff (rst_in)
    max_supply_range_out != RANGE_RESERVED;
  endproperty
  a_range_legal: assert property (p_range_legal) else $error("reserved range");

  property p_read_one;
    @(posedge clk_in) disable iff (rst_in)
    (req.rd && req.addr == SETUP_ONE_OFS) |=>
      reg_rdata_out == $past(st_q.one) && (reg_rdata_out & ~SETUP_ONE_WMSK) == '0;
  endproperty
  a_read_one: assert property (p_read_one) else $error("setup one read bad");

  property p_read_two;
    @(posedge clk_in) disable iff (rst_in)
    (req.rd && req.addr == SETUP_TWO_OFS) |=>
      reg_rdata_out == $past(st_q.two) && reg_rdata_out[31] == 1'b0;
  endproperty
  a_read_two: assert property (p_read_two) else $error("setup two read bad");

  property p_refresh_restart;
    @(posedge clk_in) disable iff (rst_in)
    (refresh && st_q.two.wdt_en) |=> st_q.wdt_ms == '0 && !$rose(st_q.report);
  endproperty
  a_refresh_restart: assert property (p_refresh_restart) else $error("refresh missed");

  property p_latch_hiz;
    @(posedge clk_in) disable iff (rst_in)
    s_latch_expiry |=> (bridge_hiz_out && wdt_fault_out) [*4];
  endproperty
  a_latch_hiz: assert property (p_latch_hiz) else $error("latch not held");

  property p_report_only;
    @(posedge clk_in) disable iff (rst_in)
    (expire && !st_q.two.watchdog_expiry_action && !st_q.latched) |=>
      wdt_fault_out && !bridge_hiz_out;
  endproperty
  a_report_only: assert property (p_report_only) else $error("report mode floated");

endmodule : mdc_config_regs

// ===== mdc_freq_duty.sv
`timescale 1ns/10ps
module mdc_freq_duty
  import mdc_pkg::*;
#(
  parameter int GATE_CYC = FREQ_GATE_CYC
) (
  input  wire logic              clk_in,    // core clock
  input  wire logic              rst_in,    // async reset, high
  input  wire logic              en_in,     // frequency input mode
  input  wire logic              edge_in,   // rising edge of speed input
  input  wire logic [14:0]       fmax_in,   // full-scale frequency, Hz
  output logic [DUTY_W-1:0]      duty_out,  // commanded duty, 255 = 100%
  output logic                   valid_out  // pulse, new duty
);

  typedef struct packed {
    mdc_fd_state_e     state;
    logic [31:0]       gate;
    logic [15:0]       edges;
    logic [15:0]       rem;
    logic [3:0]        step;
    logic [DUTY_W-1:0] quo;
    logic [DUTY_W-1:0] duty;
    logic              valid;
  } mdc_fd_st_s;

  mdc_fd_st_s  st_q, st_d;
  logic [15:0] rem_sh;

  // one gate lasts a second, so the edge count is the frequency in Hz;
  // the divide takes nine cycles, so a short gate loses no edges worth noting
  always_comb begin
    st_d       = st_q;
    st_d.valid = 1'b0;
    rem_sh     = {st_q.rem[14:0], 1'b0};
    case (st_q.state)
      FD_GATE: begin
        if (!en_in) begin
          st_d.gate  = '0;
          st_d.edges = '0;
        end else if (st_q.gate == 32'(GATE_CYC - 1)) begin
          st_d.gate  = '0;
          st_d.edges = '0;
          st_d.rem   = st_q.edges;
          st_d.quo   = '0;
          st_d.step  = '0;
          st_d.state = FD_DIV;
        end else begin
          st_d.gate = st_q.gate + 32'h1;
          if (edge_in && st_q.edges != 16'hffff) begin
            st_d.edges = st_q.edges + 16'h1;
          end
        end
      end
      FD_DIV: begin
        if (fmax_in == '0) begin
          st_d.duty  = '0;
          st_d.valid = 1'b1;
          st_d.state = FD_GATE;
        end else if (st_q.rem >= {1'b0, fmax_in} && st_q.step == '0) begin
          st_d.duty  = '1;
          st_d.valid = 1'b1;
          st_d.state = FD_GATE;
        end else if (st_q.step == 4'(DUTY_W)) begin
          st_d.duty  = st_q.quo;
          st_d.valid = 1'b1;
          st_d.state = FD_GATE;
        end else begin
          st_d.step = st_q.step + 4'h1;
          if (rem_sh >= {1'b0, fmax_in}) begin
            st_d.rem = rem_sh - {1'b0, fmax_in};
            st_d.quo = {st_q.quo[DUTY_W-2:0], 1'b1};
          end else begin
            st_d.rem = rem_sh;
            st_d.quo = {st_q.quo[DUTY_W-2:0], 1'b0};
          end
        end
      end
      default: st_d.state = FD_GATE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '{state: FD_GATE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign duty_out  = st_q.duty;
  assign valid_out = st_q.valid;

  property p_full_scale;
    @(posedge clk_in) disable iff (rst_in)
    (st_q.state == FD_DIV && st_q.step == '0 && fmax_in != '0
     && st_q.rem >= {1'b0, fmax_in}) |=> valid_out && duty_out == '1;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("full scale not 100%");

endmodule : mdc_freq_duty

// ===== mdc_host_model.sv
`timescale 1ns/10ps
module mdc_host_model (
  input  wire logic        clk_in,       // core clock
  input  wire logic [31:0] rdata_in,     // read data from the block
  output logic [7:0]       addr_out,     // register offset
  output logic [31:0]      wdata_out,    // write data
  output logic             wr_out,       // write strobe
  output logic             rd_out,       // read strobe
  output logic             refresh_out   // serial refresh pulse
);
  initial begin
    addr_out    = 8'h00;
    wdata_out   = 32'h0000_0000;
    wr_out      = 1'b0;
    rd_out      = 1'b0;
    refresh_out = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    // idle bus carries junk so a stale value is never mistaken for data
    wdata_out <= ~d;
    addr_out  <= ~a;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1;
    q = rdata_in;
  endtask : rd

  task automatic refresh();
    @(posedge clk_in);
    refresh_out <= 1'b1;
    @(posedge clk_in);
    refresh_out <= 1'b0;
  endtask : refresh
endmodule : mdc_host_model

// ===== mdc_pkg.sv
package mdc_pkg;

  // ----------------------------------------------------------------
  // clock and bus
  // ----------------------------------------------------------------
  localparam int         CLK_MHZ         = 100;
  localparam logic [7:0] SETUP_ONE_OFS   = 8'ha6;
  localparam logic [7:0] SETUP_TWO_OFS   = 8'ha8;
  localparam logic [7:0] STATUS_OFS      = 8'hfc;
  localparam logic [31:0] SETUP_ONE_RST  = 32'h0000_0000;
  localparam logic [31:0] SETUP_TWO_RST  = 32'h0000_0000;
  localparam logic [31:0] SETUP_ONE_WMSK = 32'h0ff0_001f;
  localparam logic [31:0] SETUP_TWO_WMSK = 32'h7fff_ffff;
  localparam logic [1:0] RANGE_RESERVED  = 2'h3;
  localparam int         STAT_REPORT_BIT = 0;
  localparam int         STAT_LATCH_BIT  = 1;
  localparam int         STAT_SLEEP_BIT  = 2;

  // ----------------------------------------------------------------
  // times, in their own units
  // ----------------------------------------------------------------
  localparam int SLEEP_US0     = 50;
  localparam int SLEEP_US1     = 200;
  localparam int SLEEP_US2     = 20000;
  localparam int SLEEP_US3     = 200000;
  localparam int SLEEP_CYC0    = SLEEP_US0 * CLK_MHZ;
  localparam int SLEEP_CYC1    = SLEEP_US1 * CLK_MHZ;
  localparam int SLEEP_CYC2    = SLEEP_US2 * CLK_MHZ;
  localparam int SLEEP_CYC3    = SLEEP_US3 * CLK_MHZ;
  localparam int MS_CYC        = 1000 * CLK_MHZ;
  localparam int WDT_PIN_MS0   = 100;
  localparam int WDT_PIN_MS1   = 200;
  localparam int WDT_PIN_MS2   = 500;
  localparam int WDT_PIN_MS3   = 1000;
  localparam int WDT_SER_MS0   = 1 * 1000;
  localparam int WDT_SER_MS1   = 2 * 1000;
  localparam int WDT_SER_MS2   = 3 * 1000;
  localparam int WDT_SER_MS3   = 10 * 1000;
  localparam int FREQ_GATE_MS  = 1000;
  localparam int FREQ_GATE_CYC = FREQ_GATE_MS * MS_CYC;
  localparam int DUTY_W        = 8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  rsvd_hi;
    logic        mon_en;
    logic [6:0]  target_addr;
    logic [14:0] rsvd_mid;
    logic [1:0]  drive_sel;   // 0:4.8mA 1:3.9mA 2:1.86mA 3:30.8mA
    logic        pullup_en;
    logic [1:0]  max_supply_range; // 0:15V 1:30V 2:60V
  } mdc_setup_one_s;

  typedef struct packed {
    logic        rsvd;
    logic [14:0] fmax;
    logic [1:0]  sleep_sel;
    logic        csa_auto;
    logic        volt_auto;
    logic        sleep_mode;
    logic [1:0]  clk_sel;
    logic        ext_clk_en;
    logic [2:0]  ext_clk_cfg;
    logic        wdt_en;
    logic [1:0]  refresh_interval_select;
    logic        wdt_pin_src;
    logic        watchdog_expiry_action;
  } mdc_setup_two_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mdc_bus_req_s;

  typedef enum logic {FD_GATE, FD_DIV} mdc_fd_state_e;

endpackage : mdc_pkg

// ===== mdc_sleep_timer.sv
`timescale 1ns/10ps
module mdc_sleep_timer
  import mdc_pkg::*;
#(
  parameter int CYC0 = SLEEP_CYC0,
  parameter int CYC1 = SLEEP_CYC1,
  parameter int CYC2 = SLEEP_CYC2,
  parameter int CYC3 = SLEEP_CYC3
) (
  input  wire logic       clk_in,      // core clock
  input  wire logic       rst_in,      // async reset, high
  input  wire logic       low_in,      // synchronised speed input is low
  input  wire logic [1:0] sel_in,      // entry time select
  output logic            asleep_out   // low held long enough
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        asleep;
  } mdc_sleep_st_s;

  mdc_sleep_st_s st_q, st_d;
  logic [31:0]   thr;

  always_comb begin
    case (sel_in)
      2'h0:    thr = 32'(CYC0);
      2'h1:    thr = 32'(CYC1);
      2'h2:    thr = 32'(CYC2);
      default: thr = 32'(CYC3);
    endcase
  end

  // any high sample restarts the window; counter saturates at the threshold
  always_comb begin
    st_d = st_q;
    if (!low_in) begin
      st_d.cnt    = '0;
      st_d.asleep = 1'b0;
    end else if (st_q.cnt < thr) begin
      st_d.cnt    = st_q.cnt + 32'h1;
      st_d.asleep = (st_d.cnt >= thr);
    end else begin
      st_d.asleep = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign asleep_out = st_q.asleep;

  property p_sleep_entry;
    @(posedge clk_in) disable iff (rst_in)
    $rose(st_q.asleep) |-> $past(low_in) && (st_q.cnt >= thr);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered early");

endmodule : mdc_sleep_timer

// ===== test_motor_driver_device_config_regs.sv
`timescale 1ns/10ps
module test_motor_driver_device_config_regs;
  import mdc_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        speed  = 1'b1;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, q, m1, m2, d;
  logic        wr, rd, refr, mon, pu_f, pu_s, slp, stby, csa, volt, ext_en, fault, hiz;
  logic [1:0]  drv, rng, clk_sel;
  logic [2:0]  ext_cfg;
  logic [6:0]  ta;
  logic [7:0]  fduty;
  logic        fmode  = 1'b0;
  logic        rpin   = 1'b0;
  logic        fval;
  integer      n_mismatch = 0;
  integer      n_checks = 0;
  integer      seed = 32'h82e0;
  integer      i, n;

  always #5 clk_in = ~clk_in;

  mdc_host_model u_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd), .refresh_out(refr));

  mdc_config_regs #(.SLEEP_CYC_0(20), .SLEEP_CYC_1(40), .SLEEP_CYC_2(60), .SLEEP_CYC_3(80),
    .MS_CYCLES(10), .GATE_CYCLES(200)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .speed_pin_in(speed),
    .speed_freq_mode_in(fmode), .refresh_pin_in(rpin), .serial_refresh_in(refr),
    .analog_monitor_pin_en_out(mon), .target_addr_out(ta), .serial_drive_sel_out(drv),
    .fault_indicator_pin_pu_out(pu_f), .speed_feedback_pin_pu_out(pu_s),
    .max_supply_range_out(rng), .sleep_out(slp), .standby_out(stby),
    .csa_gain_auto_out(csa), .volt_gain_auto_out(volt), .clk_sel_out(clk_sel),
    .ext_clk_en_out(ext_en), .ext_clk_cfg_out(ext_cfg), .freq_duty_out(fduty),
    .freq_duty_valid_out(fval), .wdt_fault_out(fault), .bridge_hiz_out(hiz));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic wait_for(input logic sig_sel, input integer lim);
    n = 0;
    while (((sig_sel ? hiz : fault) !== 1'b1 && sig_sel) || (!sig_sel && fault !== 1'b1))
      begin
      if (n >= lim) break;
      n++;
      @(posedge clk_in);
    end
  endtask : wait_for

  initial begin
    #600000;
    n_mismatch++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    m1 = 32'h0;
    m2 = 32'h0;
    u_host.rd(SETUP_ONE_OFS, q);
    chk(q, 32'h0000_0000);
    u_host.rd(SETUP_TWO_OFS, q);
    chk(q, 32'h0000_0000);
    for (i = 0; i < 12; i++) begin
      d = $random(seed);
      u_host.wr(SETUP_ONE_OFS, d);
      if (d[1:0] == 2'h3) d[1:0] = m1[1:0];
      m1 = d & SETUP_ONE_WMSK;
      u_host.rd(SETUP_ONE_OFS, q);
      chk(q, m1);
      chk({mon, ta, drv, pu_f, pu_s, rng},
          {m1[27], m1[26:20], m1[4:3], m1[2], m1[2], m1[1:0]});
      d = $random(seed) & 32'hffff_f7ef;
      u_host.wr(SETUP_TWO_OFS, d);
      m2 = d & SETUP_TWO_WMSK;
      u_host.rd(SETUP_TWO_OFS, q);
      chk(q, m2);
      chk({csa, volt, clk_sel, ext_en, ext_cfg}, {m2[13:12], m2[10:5]});
    end
    u_host.rd(8'h10, q);
    chk(q, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      // the last pass picks standby so both low-power outputs are seen
      u_host.wr(SETUP_TWO_OFS, (i << 14) | ((i < 3) ? 32'h800 : 32'h0));
      speed <= 1'b0;
      n = 0;
      while ((slp | stby) !== 1'b1 && n < 400) begin
        n++;
        @(posedge clk_in);
      end
      chk(n >= 20 * (i + 1) && n <= 20 * (i + 1) + 5, 1);
      chk({slp, stby}, (i < 3) ? 2'h2 : 2'h1);
      speed <= 1'b1;
      repeat (6) @(posedge clk_in);
      chk({slp, stby}, 0);
    end
    // six pin rises inside one 200-cycle gate against a full scale of ten
    u_host.wr(SETUP_TWO_OFS, 32'h000a_0000);
    fmode <= 1'b1;
    for (i = 0; i < 6; i++) begin
      repeat (10) @(posedge clk_in);
      speed <= 1'b0;
      repeat (10) @(posedge clk_in);
      speed <= 1'b1;
    end
    n = 0;
    while (fval !== 1'b1 && n < 300) begin
      n++;
      @(posedge clk_in);
    end
    chk(n >= 82 && n <= 92, 1);
    chk(fduty, (6 * 256) / 10);
    fmode <= 1'b0;
    // serial source, shortest interval: 1000 ms ticks of 10 cycles
    u_host.wr(SETUP_TWO_OFS, 32'h10);
    for (i = 0; i < 3; i++) begin
      repeat (6000) @(posedge clk_in);
      u_host.refresh();
    end
    chk(fault, 0);
    wait_for(1'b0, 10100);
    chk(n >= 9980 && n <= 10010, 1);
    chk({fault, hiz}, 2'h2);
    u_host.wr(STATUS_OFS, 32'h1);
    u_host.wr(SETUP_TWO_OFS, 32'h11);
    wait_for(1'b1, 10100);
    chk({fault, hiz}, 2'h3);
    // a second reset in mid-run clears the latch and every setting
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk({fault, hiz, mon, rng}, 0);
    u_host.rd(SETUP_TWO_OFS, q);
    chk(q, 32'h0000_0000);
    // pin source, 100 ms of 10 cycles; a serial pulse must not count
    u_host.wr(SETUP_TWO_OFS, 32'h12);
    repeat (600) @(posedge clk_in);
    rpin <= 1'b1;
    repeat (4) @(posedge clk_in);
    rpin <= 1'b0;
    repeat (500) @(posedge clk_in);
    chk(fault, 0);
    u_host.refresh();
    wait_for(1'b0, 1100);
    chk(n >= 485 && n <= 500, 1);
    chk({fault, hiz}, 2'h2);
    end_of_test();
  end
endmodule : test_motor_driver_device_config_regs
